// ==== verilog/ldcs_core.sv ====
// Purpose : Command decoder and settings store for a 4-digit LED driver
// Assumes : cmd_word/cmd_valid come from serial framing on ref_clk
// Notes   : Character table covers hex 0-F; other codes show blank
`timescale 1ns/10ps
`include "ldcs_params.svh"

// Overview of operation
// - Word 20xxH loads low nibble as digit duty n/16; bits 7-4 ignored.
// - Duty starts at 15/16 and returns there on all-data-clear.
// - Duty, digit count and decode hold until rewritten, reset or clear.
// - Word 21xxH loads low nibble 0-3 as digit count, digits 0..n.
// - Digit count starts at 3 and returns to 3 on all-data-clear.
// - In 21H word bits 7-4: 0 selects raw, 1 selects decode.
// - Decode mode is the start state and is restored by all-data-clear.
// - Raw mode: data bits 0-7 drive segments a-g then dot; start low.
// - Word 4xx0H enters standby: settings kept, outputs off.
// - Word 4xx1H clears every setting to its initial state.
// - Don't-care command bits are ignored either way.
// - Words 22xxH to 25xxH load data registers of digits 0 to 3.
// - Decode mode: data bit 6 alone drives the decimal point.
module ldcs_core #(
   parameter int TICK_CYC = `LDCS_TICK_CYC  // Cycles per sixteenth
) (
   input  wire logic        ref_clk,         // Reference clock, 20 MHz
   input  wire logic        resetn,          // Async reset, active low
   input  wire logic [15:0] cmd_word,        // Framed command word
   input  wire logic        cmd_valid,       // One-cycle word strobe
   output logic      [6:0]  segment_out,     // Segments a..g, high = on
   output logic             decimal_point_output, // Dot, high = on
   output logic      [3:0]  digit_drive,     // Digit drivers 0..3
   output logic             standby_out      // Low-bias standby state
);

   // ********************************************************************
   // Parameter check
   // ********************************************************************
   generate
      if (TICK_CYC < 2 || TICK_CYC > 4096) begin : g_bad_tick
         $error("ldcs_core: TICK_CYC out of range");
      end
   endgenerate

   // ********************************************************************
   // Command decode
   // ********************************************************************
   logic [3:0] mode;
   logic [7:0] sel;
   logic       is_load;
   logic       is_stby;
   logic       is_clear;
   logic       is_wake;
   logic       is_duty;
   logic       is_digdec;
   logic       is_data;
   logic [1:0] data_sel;

   // Only the documented fields are compared, so don't-care bits drop out
   assign mode      = cmd_word[`LDCS_MODE_HI:`LDCS_MODE_LO];
   assign sel       = cmd_word[15:8];
   assign is_load   = cmd_valid && (mode == `LDCS_MODE_LOAD);
   assign is_duty   = is_load && (sel == `LDCS_SEL_DUTY);
   assign is_digdec = is_load && (sel == `LDCS_SEL_DIGDEC);
   assign is_data   = is_load && (sel >= `LDCS_SEL_DATA0)
                      && (sel <= `LDCS_SEL_DATA3);
   assign data_sel  = 2'(sel - `LDCS_SEL_DATA0);
   assign is_stby   = cmd_valid && (mode == `LDCS_MODE_STBY)
                      && (cmd_word[3:0] == `LDCS_SUB_STANDBY);
   assign is_clear  = cmd_valid && (mode == `LDCS_MODE_STBY)
                      && (cmd_word[3:0] == `LDCS_SUB_CLEAR);
   // Only real display mode codes wake; undefined modes are ignored
   assign is_wake   = cmd_valid && (mode == `LDCS_MODE_BLANK
                      || mode == `LDCS_MODE_NORMAL
                      || mode == `LDCS_MODE_ALLON);

   // ********************************************************************
   // Settings registers
   // ********************************************************************
   logic [3:0]            duty_r;
   logic [1:0]            digcnt_r;
   logic                  decode_r;
   ldcs_pkg::ldcs_byte_t  data_r [4];
   ldcs_pkg::ldcs_disp_e  disp_r;
   logic                  standby_r;

   // Duty: only the low nibble is kept, held between commands
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         duty_r <= `LDCS_DUTY_RST;
      end else if (is_clear) begin
         duty_r <= `LDCS_DUTY_RST;
      end else if (is_duty) begin
         duty_r <= cmd_word[3:0];
      end
   end

   // Digit count; codes above 3 leave the count unchanged
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         digcnt_r <= `LDCS_DIGCNT_RST;
      end else if (is_clear) begin
         digcnt_r <= `LDCS_DIGCNT_RST;
      end else if (is_digdec && cmd_word[3:2] == 2'h0) begin
         digcnt_r <= cmd_word[1:0];
      end
   end

   // Decode select shares the 21H word; unknown codes keep the setting
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         decode_r <= `LDCS_DECODE_RST;
      end else if (is_clear) begin
         decode_r <= `LDCS_DECODE_RST;
      end else if (is_digdec && cmd_word[7:4] == `LDCS_DEC_RAW) begin
         decode_r <= 1'b0;
      end else if (is_digdec && cmd_word[7:4] == `LDCS_DEC_CHAR) begin
         decode_r <= 1'b1;
      end
   end

   // Display data per digit
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         for (int i = 0; i < 4; i++) begin
            data_r[i] <= `LDCS_DATA_RST;
         end
      end else if (is_clear) begin
         for (int i = 0; i < 4; i++) begin
            data_r[i] <= `LDCS_DATA_RST;
         end
      end else if (is_data) begin
         data_r[data_sel] <= cmd_word[7:0];
      end
   end

   // Display mode: dark until normal or all-on mode is commanded
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         disp_r <= ldcs_pkg::LDCS_DISP_BLANK;
      end else if (is_clear) begin
         disp_r <= ldcs_pkg::LDCS_DISP_BLANK;
      end else if (cmd_valid && mode == `LDCS_MODE_BLANK) begin
         disp_r <= ldcs_pkg::LDCS_DISP_BLANK;
      end else if (cmd_valid && mode == `LDCS_MODE_NORMAL) begin
         disp_r <= ldcs_pkg::LDCS_DISP_NORMAL;
      end else if (cmd_valid && mode == `LDCS_MODE_ALLON) begin
         disp_r <= ldcs_pkg::LDCS_DISP_ALLON;
      end
   end

   // Standby keeps every setting; a display mode command wakes it
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         standby_r <= 1'b0;
      end else if (is_stby) begin
         standby_r <= 1'b1;
      end else if (is_clear || is_wake) begin
         standby_r <= 1'b0;
      end
   end

   // ********************************************************************
   // Scanning and output drive
   // ********************************************************************
   logic [1:0] scan_idx;
   logic       digit_on;
   logic       run;

   assign run = !standby_r && (disp_r != ldcs_pkg::LDCS_DISP_BLANK);

   ldcs_scan #(
      .TICK_CYC   (TICK_CYC)
   ) u_scan (
      .ref_clk    (ref_clk),
      .resetn     (resetn),
      .run        (run),
      .num_digits (digcnt_r),
      .duty       (duty_r),
      .digit_idx  (scan_idx),
      .digit_on   (digit_on)
   );

   // Hex glyphs, bit 0 = segment a; codes outside 0-F are blank
   function automatic logic [6:0] char_seg(input logic [5:0] code);
      logic [6:0] s;
      s = 7'h00;
      unique case (code)
         6'h00: s = 7'h3F;
         6'h01: s = 7'h06;
         6'h02: s = 7'h5B;
         6'h03: s = 7'h4F;
         6'h04: s = 7'h66;
         6'h05: s = 7'h6D;
         6'h06: s = 7'h7D;
         6'h07: s = 7'h07;
         6'h08: s = 7'h7F;
         6'h09: s = 7'h6F;
         6'h0A: s = 7'h77;
         6'h0B: s = 7'h7C;
         6'h0C: s = 7'h39;
         6'h0D: s = 7'h5E;
         6'h0E: s = 7'h79;
         6'h0F: s = 7'h71;
         default: s = 7'h00;
      endcase
      return s;
   endfunction : char_seg

   logic [6:0]           seg_nxt;
   logic                 dp_nxt;
   logic [3:0]           dig_nxt;
   ldcs_pkg::ldcs_byte_t cur;

   // Next output pattern for the digit in its slot
   always_comb begin
      cur     = data_r[scan_idx];
      seg_nxt = 7'h00;
      dp_nxt  = 1'b0;
      dig_nxt = 4'h0;
      if (run && digit_on) begin
         dig_nxt[scan_idx] = 1'b1;
         if (disp_r == ldcs_pkg::LDCS_DISP_ALLON) begin
            seg_nxt = 7'h7F;
            dp_nxt  = 1'b1;
         end else if (decode_r) begin
            seg_nxt = char_seg(cur[5:0]);
            dp_nxt  = cur[6];
         end else begin
            seg_nxt = cur[6:0];
            dp_nxt  = cur[7];
         end
      end
   end

   // Outputs are registered to keep the pins glitch-free
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         segment_out          <= 7'h00;
         decimal_point_output <= 1'b0;
         digit_drive          <= 4'h0;
         standby_out          <= 1'b0;
      end else begin
         segment_out          <= seg_nxt;
         decimal_point_output <= dp_nxt;
         digit_drive          <= dig_nxt;
         standby_out          <= standby_r;
      end
   end

   // ********************************************************************
   // Checks
   // ********************************************************************
   property p_duty_load;
      @(posedge ref_clk) disable iff (!resetn)
      is_duty |=> duty_r == $past(cmd_word[3:0]);
   endproperty
   a_duty_load: assert property (p_duty_load)
      else $error("duty not loaded from low nibble");

   property p_clear_dflt;
      @(posedge ref_clk) disable iff (!resetn)
      is_clear |=> duty_r == 4'hF && digcnt_r == 2'h3 && decode_r
                   && disp_r == ldcs_pkg::LDCS_DISP_BLANK;
   endproperty
   a_clear_dflt: assert property (p_clear_dflt)
      else $error("clear did not restore defaults");

   property p_hold;
      @(posedge ref_clk) disable iff (!resetn)
      !cmd_valid |=> $stable(duty_r) && $stable(digcnt_r) && $stable(decode_r);
   endproperty
   a_hold: assert property (p_hold)
      else $error("setting changed without a command");

   property p_digcnt;
      @(posedge ref_clk) disable iff (!resetn)
      is_digdec && cmd_word[3:2] == 2'h0 |=> digcnt_r == $past(cmd_word[1:0]);
   endproperty
   a_digcnt: assert property (p_digcnt)
      else $error("digit count not loaded");

   property p_decode_sel;
      @(posedge ref_clk) disable iff (!resetn)
      is_digdec && cmd_word[7:5] == 3'h0 |=> decode_r == $past(cmd_word[4]);
   endproperty
   a_decode_sel: assert property (p_decode_sel)
      else $error("decode select not taken");

   property p_data_load;
      @(posedge ref_clk) disable iff (!resetn)
      is_data |=> data_r[$past(data_sel)] == $past(cmd_word[7:0]);
   endproperty
   a_data_load: assert property (p_data_load)
      else $error("data register not loaded");

   property p_raw_map;
      @(posedge ref_clk) disable iff (!resetn)
      run && digit_on && !decode_r && disp_r == ldcs_pkg::LDCS_DISP_NORMAL
      |=> {decimal_point_output, segment_out} == $past(cur);
   endproperty
   a_raw_map: assert property (p_raw_map)
      else $error("raw mode segments differ from data");

   property p_dp_decode;
      @(posedge ref_clk) disable iff (!resetn)
      run && digit_on && decode_r && disp_r == ldcs_pkg::LDCS_DISP_NORMAL
      |=> decimal_point_output == $past(cur[6]);
   endproperty
   a_dp_decode: assert property (p_dp_decode)
      else $error("decimal point not from data bit 6");

   property p_standby_dark;
      @(posedge ref_clk) disable iff (!resetn)
      is_stby |=> ##1 standby_out && digit_drive == 4'h0
                  && segment_out == 7'h00;
   endproperty
   a_standby_dark: assert property (p_standby_dark)
      else $error("outputs not off in standby");

endmodule : ldcs_core

// ==== verilog/ldcs_params.svh ====
// Purpose : Constants for the LED display command and settings block
// Assumes : 16-bit command words, upper nibble selects the mode
// Notes   : Timing counts are derived from the reference clock rate
`ifndef LDCS_PARAMS_SVH
`define LDCS_PARAMS_SVH

// ********************************************************************
// Command field positions and codes
// ********************************************************************
`define LDCS_MODE_HI      15
`define LDCS_MODE_LO      12
`define LDCS_MODE_BLANK   4'h0
`define LDCS_MODE_NORMAL  4'h1
`define LDCS_MODE_LOAD    4'h2
`define LDCS_MODE_ALLON   4'h3
`define LDCS_MODE_STBY    4'h4
`define LDCS_SEL_DUTY     8'h20
`define LDCS_SEL_DIGDEC   8'h21
`define LDCS_SEL_DATA0    8'h22
`define LDCS_SEL_DATA3    8'h25
`define LDCS_SUB_STANDBY  4'h0
`define LDCS_SUB_CLEAR    4'h1
`define LDCS_DEC_RAW      4'h0
`define LDCS_DEC_CHAR     4'h1

// ********************************************************************
// Reset values
// ********************************************************************
`define LDCS_DUTY_RST     4'hF
`define LDCS_DIGCNT_RST   2'h3
`define LDCS_DECODE_RST   1'b1
`define LDCS_DATA_RST     8'h00

// ********************************************************************
// Timing: one sixteenth of a digit slot
// ********************************************************************
`define LDCS_CLK_PERIOD_NS 50
`define LDCS_TICK_NS       3200
`define LDCS_TICK_CYC \
   ((`LDCS_TICK_NS + `LDCS_CLK_PERIOD_NS - 1) / `LDCS_CLK_PERIOD_NS)

`endif

// ==== verilog/ldcs_pkg.sv ====
// Purpose : Types shared by the LED display command block
// Assumes : Nothing beyond the constants header
// Notes   : Holds only types; numbers live in ldcs_params.svh
package ldcs_pkg;

   // ********************************************************************
   // Display mode selected by the top-level mode commands
   // ********************************************************************
   typedef enum logic [1:0] {
      LDCS_DISP_BLANK,
      LDCS_DISP_NORMAL,
      LDCS_DISP_ALLON
   } ldcs_disp_e;

   typedef logic [7:0] ldcs_byte_t;

endpackage : ldcs_pkg

// ==== verilog/ldcs_scan.sv ====
// Purpose : Digit scanner with sixteen-step on-time control
// Assumes : Same clock as the command decoder
// Notes   : A slot is sixteen ticks; the digit is on for duty ticks
`timescale 1ns/10ps
module ldcs_scan #(
   parameter int TICK_CYC = 64              // Cycles per sixteenth
) (
   input  wire logic       ref_clk,         // Reference clock
   input  wire logic       resetn,          // Async reset, active low
   input  wire logic       run,             // Scanning allowed
   input  wire logic [1:0] num_digits,      // Highest enabled digit
   input  wire logic [3:0] duty,            // On-time in sixteenths
   output logic      [1:0] digit_idx,       // Digit in its slot
   output logic            digit_on         // Digit may be lit now
);

   localparam int PRE_W = $clog2(TICK_CYC);

   // ********************************************************************
   // Parameter check
   // ********************************************************************
   generate
      if (TICK_CYC < 2) begin : g_bad_tick
         $error("ldcs_scan: TICK_CYC must be at least 2");
      end
   endgenerate

   logic [PRE_W-1:0] pre_r;
   logic [3:0]       tick_r;
   logic [1:0]       idx_r;
   logic             tick_end;

   assign tick_end = (pre_r == PRE_W'(TICK_CYC - 1));

   // Prescaler; idle while stopped so a restart begins a clean slot
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         pre_r <= '0;
      end else if (!run || tick_end) begin
         pre_r <= '0;
      end else begin
         pre_r <= pre_r + PRE_W'(1);
      end
   end

   // Sixteenth counter within a slot
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         tick_r <= 4'h0;
      end else if (!run) begin
         tick_r <= 4'h0;
      end else if (tick_end) begin
         tick_r <= tick_r + 4'h1;
      end
   end

   // Cyclic digit select; wraps early if the count was lowered
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         idx_r <= 2'h0;
      end else if (!run || idx_r > num_digits) begin
         idx_r <= 2'h0;
      end else if (tick_end && tick_r == 4'hF) begin
         idx_r <= (idx_r == num_digits) ? 2'h0 : idx_r + 2'h1;
      end
   end

   assign digit_idx = idx_r;
   // Duty 0 never lights, 15 leaves one dark sixteenth per slot
   assign digit_on  = run && (tick_r < duty) && (idx_r <= num_digits);

   // ********************************************************************
   // Checks
   // ********************************************************************
   property p_scan_step;
      @(posedge ref_clk) disable iff (!resetn)
      run && tick_end && tick_r == 4'hF && idx_r < num_digits
      |=> idx_r == $past(idx_r) + 2'h1;
   endproperty
   a_scan_step: assert property (p_scan_step)
      else $error("scan did not step to the next digit");

   // The digit may only move at the end of its slot
   property p_scan_hold;
      @(posedge ref_clk) disable iff (!resetn)
      run && !(tick_end && tick_r == 4'hF) && idx_r <= num_digits
      |=> $stable(idx_r);
   endproperty
   a_scan_hold: assert property (p_scan_hold)
      else $error("digit changed inside its slot");

endmodule : ldcs_scan

// ==== test/ldcs_host_model.sv ====
// Purpose : Host processor model that issues command words to the block
// Assumes : Serial framing is already done; one word per strobe
// Notes   : Word lines carry the inverse of the last word between strobes
`timescale 1ns/10ps
module ldcs_host_model (
   input  wire logic        ref_clk,    // Reference clock
   output logic      [15:0] cmd_word,   // Framed command word
   output logic             cmd_valid   // One-cycle word strobe
);

   // ********************************************************************
   // Command tasks
   // ********************************************************************

   // Idle lines at time zero
   initial begin
      cmd_word  = 16'h0000;
      cmd_valid = 1'b0;
   end

   // Entered just after a rising edge; the word is held until the next
   // edge takes it, then an edge passes so the strobe is never redriven
   // in the same time step
   task automatic send(input logic [15:0] w);
      cmd_word  = w;
      cmd_valid = 1'b1;
      @(posedge ref_clk);
      #1;
      cmd_valid = 1'b0;
      cmd_word  = ~w;                   // Stale word must not look valid
      @(posedge ref_clk);
      #1;
   endtask : send

   // Decode choice and digit count always travel in one word
   task automatic set_digdec(input logic [3:0] dec, input logic [3:0] cnt);
      send({8'h21, dec, cnt});
   endtask : set_digdec

   // Nothing lights until normal or all-on mode follows power-on or a clear
   task automatic go_normal();
      send(16'h1000);
   endtask : go_normal

   // Discrete LEDs want the segment bits passed straight through
   task automatic raw_mode(input logic [3:0] cnt);
      set_digdec(4'h0, cnt);
   endtask : raw_mode

endmodule : ldcs_host_model

// ==== test/tb.sv ====
// Purpose : Self-checking bench for the LED command and settings block
// Assumes : Short sixteenth (TICK_CYC = 2) so a slot is 32 cycles
// Notes   : Windows of 384 cycles span whole scan periods for 1..4 digits
`timescale 1ns/10ps
module tb;
   localparam int TCK   = 2;            // Cycles per sixteenth
   localparam int WIN   = 384;          // Multiple of every scan period
   localparam int LIMIT = 20000;        // Ceiling on the whole run

   logic        ref_clk;                // Reference clock
   logic        resetn;                 // Reset, active low
   logic [15:0] cmd_word;               // Command word
   logic        cmd_valid;              // Word strobe
   logic [6:0]  segment_out;            // Segments a..g
   logic        decimal_point_output;   // Dot segment
   logic [3:0]  digit_drive;            // Digit drivers
   logic        standby_out;            // Standby flag
   int          err_total;              // Mismatches
   int          num_checks;             // Comparisons
   int          cyc;                    // Cycle counter

   ldcs_core #(.TICK_CYC(TCK)) uut (
      .ref_clk              (ref_clk),
      .resetn               (resetn),
      .cmd_word             (cmd_word),
      .cmd_valid            (cmd_valid),
      .segment_out          (segment_out),
      .decimal_point_output (decimal_point_output),
      .digit_drive          (digit_drive),
      .standby_out          (standby_out)
   );

   ldcs_host_model host (
      .ref_clk   (ref_clk),
      .cmd_word  (cmd_word),
      .cmd_valid (cmd_valid)
   );

   // ********************************************************************
   // Clock, timeout and reporting
   // ********************************************************************

   // 20 MHz clock
   initial ref_clk = 1'b0;
   always #25 ref_clk = ~ref_clk;

   // A hang counts as a mismatch and ends the run
   always @(posedge ref_clk) begin
      cyc = cyc + 1;
      if (cyc == LIMIT) begin
         err_total = err_total + 1;
         tally_and_finish();
      end
   end

   task automatic chk(input string name, input logic [15:0] exp,
                      input logic [15:0] got);
      num_checks = num_checks + 1;
      if (got !== exp) begin
         err_total = err_total + 1;
         $display("[FAIL] %s expected %0h seen %0h", name, exp, got);
      end
   endtask : chk

   task automatic tally_and_finish();
      if (err_total == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : tally_and_finish

   // Watch whole scan periods: lit cycles per digit, the {dot, segments}
   // seen while lit, and any overlap or segment left on between digits
   task automatic disp(input int duty, input int cnt, input logic [7:0] e0,
                       input logic [7:0] e1, input logic [7:0] e2,
                       input logic [7:0] e3);
      int         on [4];
      logic [7:0] seen [4];
      logic [7:0] eb [4];
      int         bad;
      int         exp_on;
      eb = '{e0, e1, e2, e3};
      on = '{0, 0, 0, 0};
      seen = '{8'h00, 8'h00, 8'h00, 8'h00};
      bad = 0;
      repeat (4) @(posedge ref_clk);
      for (int i = 0; i < WIN; i++) begin
         @(negedge ref_clk);
         case (digit_drive)
            4'h0: if ({decimal_point_output, segment_out} !== 8'h00) bad++;
            4'h1, 4'h2, 4'h4, 4'h8: begin
               for (int d = 0; d < 4; d++) begin
                  if (digit_drive[d] === 1'b1) begin
                     on[d]++;
                     seen[d] = {decimal_point_output, segment_out};
                  end
               end
            end
            default: bad++;
         endcase
      end
      @(posedge ref_clk);
      #1;
      chk("scan_overlap", 16'h0000, bad[15:0]);
      for (int d = 0; d < 4; d++) begin
         exp_on = (d <= cnt) ? (12 / (cnt + 1)) * TCK * duty : 0;
         chk("lit_cycles", exp_on[15:0], on[d][15:0]);
         if (exp_on > 0) begin
            chk("segments", {8'h00, eb[d]}, {8'h00, seen[d]});
         end
      end
   endtask : disp

   // ********************************************************************
   // Main sequence
   // ********************************************************************
   initial begin
      err_total  = 0;
      num_checks = 0;
      cyc        = 0;
      resetn     = 1'b0;
      repeat (2) @(posedge ref_clk);
      #1;
      resetn = 1'b1;
      disp(0, 3, 8'h00, 8'h00, 8'h00, 8'h00);
      // Load digits while blank; digit 1 carries a dot on data bit 6
      host.send(16'h220A);
      host.send(16'h234B);
      host.send(16'h240C);
      host.send(16'h250D);
      disp(0, 3, 8'h00, 8'h00, 8'h00, 8'h00);
      host.go_normal();
      disp(15, 3, 8'h77, 8'hFC, 8'h39, 8'h5E);
      // Duty with upper nibble set, then zero duty
      host.send(16'h20F8);
      disp(8, 3, 8'h77, 8'hFC, 8'h39, 8'h5E);
      host.send(16'h2000);
      disp(0, 3, 8'h77, 8'hFC, 8'h39, 8'h5E);
      // Duty 5 with don't-care bits, then an unused select that is ignored
      host.send(16'h2095);
      host.send(16'h2A95);
      for (int c = 0; c < 4; c++) begin
         host.set_digdec(4'h1, c[3:0]);
         disp(5, c, 8'h77, 8'hFC, 8'h39, 8'h5E);
      end
      // Out-of-range fields leave both settings alone
      host.send(16'h2127);
      disp(5, 3, 8'h77, 8'hFC, 8'h39, 8'h5E);
      // Raw mode: the data byte maps straight to {dot, g..a}
      host.raw_mode(4'h3);
      host.send(16'h22A5);
      disp(5, 3, 8'hA5, 8'h4B, 8'h0C, 8'h0D);
      // Standby keeps settings but darkens everything
      host.send(16'h40F0);
      chk("standby", 16'h0001, {15'h0000, standby_out});
      // An undefined mode code must not wake the block
      host.send(16'hF001);
      chk("standby", 16'h0001, {15'h0000, standby_out});
      disp(0, 3, 8'h00, 8'h00, 8'h00, 8'h00);
      host.go_normal();
      chk("standby", 16'h0000, {15'h0000, standby_out});
      disp(5, 3, 8'hA5, 8'h4B, 8'h0C, 8'h0D);
      // Blank and all-on leave the settings underneath untouched
      host.send(16'h0FFF);
      disp(0, 3, 8'h00, 8'h00, 8'h00, 8'h00);
      host.send(16'h3000);
      disp(5, 3, 8'hFF, 8'hFF, 8'hFF, 8'hFF);
      host.go_normal();
      disp(5, 3, 8'hA5, 8'h4B, 8'h0C, 8'h0D);
      // Clear with don't-care bits set restores every default
      host.send(16'h4AB1);
      disp(0, 3, 8'h00, 8'h00, 8'h00, 8'h00);
      host.go_normal();
      disp(15, 3, 8'h3F, 8'h3F, 8'h3F, 8'h3F);
      // Reset in mid-run after moving every setting except the data of digits 1-3 off its default
      host.send(16'h2003);
      host.raw_mode(4'h1);
      host.send(16'h2281);
      disp(3, 1, 8'h81, 8'h00, 8'h00, 8'h00);
      resetn = 1'b0;
      repeat (2) @(posedge ref_clk);
      #1;
      chk("rst_seg", 16'h0, {9'h0, segment_out});
      chk("rst_dp", 16'h0, {15'h0, decimal_point_output});
      chk("rst_dig", 16'h0, {11'h0, standby_out, digit_drive});
      resetn = 1'b1;
      disp(0, 3, 8'h00, 8'h00, 8'h00, 8'h00);
      host.go_normal();
      disp(15, 3, 8'h3F, 8'h3F, 8'h3F, 8'h3F);
      tally_and_finish();
   end

endmodule : tb
